//--- inc/irq_map_pkg.sv
// Register map, field layout and carrier types of the interrupt enable block
package irq_map_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  // Register numbers
  localparam logic [7:0] LVL7_EN_ADDR = 8'h0A;
  localparam logic [7:0] BUS_EN_ADDR  = 8'h0C;
  localparam logic [7:0] PRI10_ADDR   = 8'h0D;
  localparam logic [7:0] PRI32_ADDR   = 8'h0E;
  localparam logic [7:0] LOC_EN_ADDR  = 8'h10;
  localparam logic [7:0] EVT_STAT_ADDR = 8'h11;
  localparam logic [7:0] EVT_MASK_ADDR = 8'h12;
  localparam logic [7:0] PIN_STAT_ADDR = 8'h13;
  localparam logic [7:0] LATCH_ADDR    = 8'h14;
  // Level-7 enable bit positions
  localparam int unsigned NMI_BIT = 0;
  localparam int unsigned MEM_BIT = 1;
  localparam int unsigned ACF_BIT = 2;
  localparam int unsigned SYF_BIT = 3;
  localparam int unsigned ISO_BIT = 4;
  // Priority field positions
  localparam int unsigned PRI_LO = 0;
  localparam int unsigned PRI_HI = 4;
  localparam int unsigned PRI_W  = 3;
  // Fixed read values, reset values and source counts
  localparam logic [7:0] PRI_FILL = 8'h88;
  localparam logic [2:0] PRI_MASKED = 3'h0;
  localparam logic [3:0] EN7_RST  = 4'h0;
  localparam logic [5:0] LOC_RST  = 6'h00;
  localparam logic [6:0] BUS_RST  = 7'h00;
  localparam logic [2:0] EVT_RST  = 3'h0;
  localparam int unsigned N_SRC7 = 5;
  localparam int unsigned N_LOC  = 6;
  localparam int unsigned N_MAP  = 4;
  localparam int unsigned N_BUS  = 7;
  // Event bits: 0 level-7 latch set, 1 local request, 2 bus request
  localparam int unsigned N_EVT = 3;

  typedef struct packed {
    logic [N_SRC7-1:0] sync1;
    logic [N_SRC7-1:0] sync2;
    logic [N_LOC-1:0]  loc1;
    logic [N_LOC-1:0]  loc2;
    logic [N_BUS-1:0]  bus1;
    logic [N_BUS-1:0]  bus2;
    logic [3:0]        en7;
    logic [N_SRC7-1:0] latch;
    logic [N_LOC-1:0]  loc_en;
    logic [N_BUS-1:0]  bus_en;
    logic [N_MAP*PRI_W-1:0] pri;
    logic [N_EVT-1:0]  evt;
    logic [N_EVT-1:0]  evt_mask;
    logic [DATA_W-1:0] rdata;
    logic [2:0]        cpu_level;
    logic              lvl7_req;
    logic [N_LOC-1:0]  loc_req;
    logic [N_BUS-1:0]  bus_req;
  } state_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_s;
endpackage

//--- logic/irq_enable_map.sv
// Interrupt enable and local level-mapping register set
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
module irq_enable_map
  import irq_map_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire reg_req_s          req,
  output logic [DATA_W-1:0]      rdata,
  input  wire logic              isolation_event,
  input  wire logic              sysfail_input_pin,
  input  wire logic              acfail_input_pin,
  input  wire logic              memory_error_pin,
  input  wire logic              nonmaskable_input_pin,
  input  wire logic [N_LOC-1:0]  local_request_pins,
  input  wire logic [N_BUS-1:0]  bus_level_pins,
  output logic                   level7_request,
  output logic [2:0]             cpu_level,
  output logic [N_LOC-1:0]       local_request,
  output logic [N_BUS-1:0]       bus_level_request,
  output logic                   irq
);

  state_s s_r;
  state_s s_nxt;

  // Highest nonzero priority among enabled, asserted mapped pins
  function automatic logic [2:0] best_level(
    input logic [N_MAP*PRI_W-1:0] pri,
    input logic [N_LOC-1:0]       act
  );
    logic [2:0] best;
    logic [2:0] f;
    best = PRI_MASKED;
    for (int i = 0; i < N_MAP; i++) begin
      f = pri[i*PRI_W +: PRI_W];
      if (act[i] && f != PRI_MASKED && f > best) begin
        best = f;
      end
    end
    return best;
  endfunction

  logic [N_SRC7-1:0] raw7;
  assign raw7 = {isolation_event, sysfail_input_pin, acfail_input_pin,
                 memory_error_pin, nonmaskable_input_pin};

  // Next-state logic
  always_comb begin
    logic [N_SRC7-1:0] en_all;
    logic [N_SRC7-1:0] set7;
    logic [N_LOC-1:0]  loc_act;
    logic [N_EVT-1:0]  evt_set;
    logic [N_EVT-1:0]  evt_clr;
    logic [2:0]        lvl;
    en_all  = '0;
    set7    = '0;
    loc_act = '0;
    evt_set = '0;
    evt_clr = '0;
    lvl     = PRI_MASKED;
    s_nxt   = s_r;
    // Two-flop synchronisers on pins
    s_nxt.sync1 = raw7;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.loc1  = local_request_pins;
    s_nxt.loc2  = s_r.loc1;
    s_nxt.bus1  = bus_level_pins;
    s_nxt.bus2  = s_r.bus1;
    // Level-7 latches; non-maskable always enabled
    en_all = {s_r.en7, 1'b1};
    set7   = s_r.sync2 & en_all;
    s_nxt.latch = s_r.latch & en_all;
    if (req.wr && req.addr == LVL7_EN_ADDR) begin
      s_nxt.en7 = req.wdata[ISO_BIT:MEM_BIT];
      if (!req.wdata[NMI_BIT]) begin
        s_nxt.latch[NMI_BIT] = 1'b0;
      end
    end
    s_nxt.latch = s_nxt.latch | set7; // set wins over clear
    // Plain enable, priority and event mask registers; event status clear strobe
    if (req.wr) begin
      case (req.addr)
        LOC_EN_ADDR: s_nxt.loc_en = req.wdata[N_LOC-1:0];
        BUS_EN_ADDR: s_nxt.bus_en = req.wdata[N_BUS-1:0];
        PRI10_ADDR: begin
          s_nxt.pri[0 +: PRI_W]       = req.wdata[PRI_LO +: PRI_W];
          s_nxt.pri[PRI_W +: PRI_W]   = req.wdata[PRI_HI +: PRI_W];
        end
        PRI32_ADDR: begin
          s_nxt.pri[2*PRI_W +: PRI_W] = req.wdata[PRI_LO +: PRI_W];
          s_nxt.pri[3*PRI_W +: PRI_W] = req.wdata[PRI_HI +: PRI_W];
        end
        EVT_STAT_ADDR: evt_clr = req.wdata[N_EVT-1:0];
        EVT_MASK_ADDR: s_nxt.evt_mask = req.wdata[N_EVT-1:0];
        default: ;
      endcase
    end
    // Requests toward the local CPU
    loc_act = s_r.loc2 & s_r.loc_en;
    for (int i = 0; i < N_MAP; i++) begin
      if (s_r.pri[i*PRI_W +: PRI_W] == PRI_MASKED) begin
        loc_act[i] = 1'b0;
      end
    end
    lvl = best_level(s_r.pri, loc_act);
    s_nxt.cpu_level = lvl;
    s_nxt.loc_req   = loc_act;
    s_nxt.bus_req   = s_r.bus2 & s_r.bus_en;
    s_nxt.lvl7_req  = |s_r.latch;
    // Sticky events, write one to clear, set wins
    evt_set = {|s_nxt.bus_req, |loc_act, |set7};
    s_nxt.evt = (s_r.evt & ~evt_clr) | evt_set;
    // Read data, one cycle after the strobe
    s_nxt.rdata = '0;
    if (req.rd) begin
      case (req.addr)
        LVL7_EN_ADDR:  s_nxt.rdata = {3'h0, s_r.en7, 1'b1};
        LOC_EN_ADDR:   s_nxt.rdata = {2'h0, s_r.loc_en};
        BUS_EN_ADDR:   s_nxt.rdata = {1'b0, s_r.bus_en};
        PRI10_ADDR:    s_nxt.rdata = PRI_FILL |
          {1'b0, s_r.pri[PRI_W +: PRI_W], 1'b0, s_r.pri[0 +: PRI_W]};
        PRI32_ADDR:    s_nxt.rdata = PRI_FILL |
          {1'b0, s_r.pri[3*PRI_W +: PRI_W], 1'b0,
           s_r.pri[2*PRI_W +: PRI_W]};
        EVT_STAT_ADDR: s_nxt.rdata = {5'h00, s_r.evt};
        EVT_MASK_ADDR: s_nxt.rdata = {5'h00, s_r.evt_mask};
        PIN_STAT_ADDR: s_nxt.rdata = {3'h0, s_r.sync2};
        LATCH_ADDR:    s_nxt.rdata = {3'h0, s_r.latch};
        default:       s_nxt.rdata = '0;
      endcase
    end
    // Synchronous reset
    if (srst) begin
      s_nxt = '0;
      s_nxt.en7    = EN7_RST;
      s_nxt.loc_en = LOC_RST;
      s_nxt.bus_en = BUS_RST;
      s_nxt.evt    = EVT_RST;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    s_r <= s_nxt;
  end

  // Outputs
  assign rdata             = s_r.rdata;
  assign level7_request    = s_r.lvl7_req;
  assign cpu_level         = s_r.cpu_level;
  assign local_request     = s_r.loc_req;
  assign bus_level_request = s_r.bus_req;
  assign irq               = |(s_r.evt & s_r.evt_mask);

endmodule

//--- dv/irq_map_checker.sv
// Port assertions of the interrupt enable block
`timescale 1ns/10ps
module irq_map_checker
  import irq_map_pkg::*;
(
  input wire logic             mclk,
  input wire logic             srst,
  input wire reg_req_s         req,
  input wire logic [7:0]       rdata,
  input wire logic [N_LOC-1:0] local_request_pins,
  input wire logic [N_BUS-1:0] bus_level_pins,
  input wire logic [2:0]       cpu_level,
  input wire logic [N_LOC-1:0] local_request,
  input wire logic [N_BUS-1:0] bus_level_request
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // Read of one register
  sequence rd_of(logic [7:0] a);
    req.rd && req.addr == a;
  endsequence
  lvl7_fill_a: assert property (
    rd_of(LVL7_EN_ADDR) |=> rdata[7:5] == 3'h0 && rdata[0])
    else $error("level-7 fixed bits wrong");
  bus_fill_a: assert property (
    rd_of(BUS_EN_ADDR) |=> !rdata[7]) else $error("bus bit 7 set");
  loc_fill_a: assert property (
    rd_of(LOC_EN_ADDR) |=> rdata[7:6] == 2'h0)
    else $error("local enable fill wrong");
  pri10_fill_a: assert property (
    rd_of(PRI10_ADDR) |=> rdata[7] && rdata[3])
    else $error("pin 1/0 fill wrong");
  pri32_fill_a: assert property (
    rd_of(PRI32_ADDR) |=> rdata[7] && rdata[3])
    else $error("pin 3/2 fill wrong");
  loc_src_a: assert property (
    (local_request & ~$past(local_request_pins, 3)) == 6'h00)
    else $error("local request without pin");
  bus_src_a: assert property (
    (bus_level_request & ~$past(bus_level_pins, 3)) == 7'h00)
    else $error("bus request without pin");
  cpu_lvl_a: assert property (
    cpu_level != 3'h0 |-> local_request[3:0] != 4'h0)
    else $error("level without mapped pin");
endmodule
bind irq_enable_map irq_map_checker u_irq_map_checker(.mclk(mclk),
  .srst(srst), .req(req), .rdata(rdata),
  .local_request_pins(local_request_pins),
  .bus_level_pins(bus_level_pins), .cpu_level(cpu_level),
  .local_request(local_request), .bus_level_request(bus_level_request));

//--- dv/irq_src_model.sv
// On-card interrupt sources and bus levels
`timescale 1ns/10ps
module irq_src_model
  import irq_map_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic [17:0]  want,
  output logic [N_SRC7-1:0] l7,
  output logic [N_LOC-1:0]  loc,
  output logic [N_BUS-1:0]  bus
);
  initial {l7, loc, bus} = '0;
  // Sources change just after the edge
  always @(posedge mclk) begin
    {l7, loc, bus} <= want;
  end
endmodule

//--- dv/tb.sv
// Self-checking bench of the interrupt enable block
`timescale 1ns/10ps
module tb;
  import irq_map_pkg::*;
  logic mclk = 0, srst = 1, rd_d = 0, l7_q, irq;
  reg_req_s req = '0;
  logic [17:0] want = '0;
  logic [7:0] rdata, lfsr = 8'h39, exp_q[$];
  logic [4:0] l7;
  logic [5:0] loc, loc_q;
  logic [6:0] bus, bus_q;
  logic [2:0] lvl, lvl_e;
  int bad_count = 0, n_checks = 0;
  initial forever #2 mclk = ~mclk;
  irq_src_model u_irq_src_model(.mclk(mclk), .want(want), .l7(l7),
    .loc(loc), .bus(bus));
  irq_enable_map u_irq_enable_map(.mclk(mclk), .srst(srst), .req(req),
    .rdata(rdata), .isolation_event(l7[4]), .sysfail_input_pin(l7[3]),
    .acfail_input_pin(l7[2]), .memory_error_pin(l7[1]),
    .nonmaskable_input_pin(l7[0]), .local_request_pins(loc),
    .bus_level_pins(bus), .level7_request(l7_q), .cpu_level(lvl),
    .local_request(loc_q), .bus_level_request(bus_q), .irq(irq));
  task automatic chk(input logic [7:0] s, e, input string n);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One bus cycle, strobe held for one cycle
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge mclk);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge mclk);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    exp_q.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Read strobe taken at the edge; data stands until the next edge
  always @(posedge mclk) begin
    rd_d <= req.rd & !srst;
  end
  // Read data compared mid-cycle, clear of the launching edge
  always @(negedge mclk) begin
    if (rd_d) chk(rdata, exp_q.pop_front(), "rdata");
  end
  initial begin
    repeat (3000) @(posedge mclk);
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge mclk);
    srst <= 0;
    rd(LVL7_EN_ADDR, 8'h01);
    rd(BUS_EN_ADDR, 8'h00);
    rd(PRI10_ADDR, 8'h88);
    rd(PRI32_ADDR, 8'h88);
    rd(LOC_EN_ADDR, 8'h00);
    rd(8'h20, 8'h00);
    // Random values written and read back
    repeat (8) begin
      lfsr = nxt(lfsr);
      acc(1'b1, PRI10_ADDR, lfsr);
      rd(PRI10_ADDR, lfsr | 8'h88);
      acc(1'b1, LVL7_EN_ADDR, lfsr);
      rd(LVL7_EN_ADDR, {3'h0, lfsr[4:1], 1'b1});
      acc(1'b1, BUS_EN_ADDR, lfsr);
      rd(BUS_EN_ADDR, lfsr & 8'h7F);
      acc(1'b1, LOC_EN_ADDR, lfsr);
      rd(LOC_EN_ADDR, lfsr & 8'h3F);
    end
    // All local and bus sources active, only sysfail at level 7, pin 3 masked by zero level
    acc(1'b1, LOC_EN_ADDR, 8'h3F);
    acc(1'b1, BUS_EN_ADDR, 8'h55);
    acc(1'b1, PRI32_ADDR, 8'h02);
    acc(1'b1, LVL7_EN_ADDR, 8'h08);
    acc(1'b1, EVT_MASK_ADDR, 8'h07);
    want <= 18'h11FFF;
    repeat (6) @(posedge mclk);
    lvl_e = lfsr[6:4] > lfsr[2:0] ? lfsr[6:4] : lfsr[2:0];
    if (lvl_e < 3'h2) lvl_e = 3'h2;
    @(negedge mclk);
    chk({5'h0, lvl}, {5'h0, lvl_e}, "cpu_level");
    chk({2'h0, loc_q}, {4'h3, 2'h1, |lfsr[6:4], |lfsr[2:0]},
      "local");
    chk({1'h0, bus_q}, 8'h55, "bus");
    chk({7'h0, l7_q}, 8'h01, "level7");
    chk({7'h0, irq}, 8'h01, "irq");
    rd(LATCH_ADDR, 8'h08);
    rd(EVT_STAT_ADDR, 8'h07);
    acc(1'b1, EVT_MASK_ADDR, 8'h00);
    @(negedge mclk);
    chk({7'h0, irq}, 8'h00, "irq masked");
    // Non-maskable latch, sticky until written with zero
    acc(1'b1, LVL7_EN_ADDR, 8'h00);
    want <= 18'h02000;
    repeat (6) @(posedge mclk);
    rd(PIN_STAT_ADDR, 8'h01);
    want <= 18'h00000;
    repeat (6) @(posedge mclk);
    rd(LATCH_ADDR, 8'h01);
    acc(1'b1, LVL7_EN_ADDR, 8'h01);
    rd(LATCH_ADDR, 8'h01);
    acc(1'b1, LVL7_EN_ADDR, 8'h00);
    acc(1'b1, EVT_STAT_ADDR, 8'h07);
    rd(LATCH_ADDR, 8'h00);
    rd(EVT_STAT_ADDR, 8'h00);
    repeat (3) @(posedge mclk);
    stop_test();
  end
endmodule
